// ---- src/dcas_pkg.sv ----
// Shared constants, types and helpers of the dual-channel asynchronous serial block.
package dcas_pkg;
  // Number of independent serial channels.
  localparam int DCAS_CH = 2;
  // Register byte offsets inside one 16-byte channel window.
  localparam logic [3:0] DCAS_OFF_DATA = 4'h0;
  localparam logic [3:0] DCAS_OFF_STAT = 4'h4;
  localparam logic [3:0] DCAS_OFF_CTRL = 4'h8;
  localparam logic [3:0] DCAS_OFF_DIV = 4'hc;
  // Address bit that picks the channel window.
  localparam int DCAS_CH_BIT = 4;
  // Status register bit positions.
  localparam int DCAS_ST_RXAV = 0;
  localparam int DCAS_ST_TXND = 1;
  localparam int DCAS_ST_PERR = 2;
  localparam int DCAS_ST_FERR = 3;
  localparam int DCAS_ST_OVR = 4;
  localparam int DCAS_ST_TXBSY = 5;
  localparam int DCAS_ST_RXBSY = 6;
  // Reset values: eight data bits, one stop bit, no parity, x16.
  localparam logic [12:0] DCAS_CTRL_RST = 13'h000c;
  localparam logic [15:0] DCAS_DIV_RST = 16'h0000;
  // Ticks per bit for the three clock multiples.
  localparam logic [6:0] DCAS_OVS16 = 7'h10;
  localparam logic [6:0] DCAS_OVS32 = 7'h20;
  localparam logic [6:0] DCAS_OVS64 = 7'h40;
  // Control word of one channel.
  typedef struct packed {
    logic err_ie;
    logic tx_ie;
    logic rx_ie;
    logic wait_en;
    logic dma_en;
    logic par_odd;
    logic par_en;
    logic [1:0] stop_sel;
    logic [1:0] len_sel;
    logic [1:0] mul_sel;
  } dcas_cfg_t;
  // One received character with its check results.
  typedef struct packed {
    logic [7:0] data;
    logic perr;
    logic ferr;
  } dcas_rxres_t;
  // Ticks per bit for a multiple select; code 3 also means x64.
  function automatic logic [6:0] dcas_ovs(input logic [1:0] s);
    return (s == 2'h0) ? DCAS_OVS16 : (s == 2'h1) ? DCAS_OVS32 : DCAS_OVS64;
  endfunction
  // Index of the last data bit: five to eight bits.
  function automatic logic [2:0] dcas_last(input logic [1:0] s);
    return 3'h4 + {1'b0, s};
  endfunction
  // Stop length in ticks: one, one and a half or two bit times.
  function automatic logic [7:0] dcas_stop(input logic [6:0] o, input logic [1:0] s);
    logic [7:0] h;
    h = {2'h0, o[6:1]};
    return (s == 2'h0) ? 8'(h * 8'h02) : (s == 2'h1) ? 8'(h * 8'h03) : 8'(h * 8'h04);
  endfunction
endpackage

// ---- src/dcas_tx.sv ----
// Transmit serialiser of one channel.
`timescale 1ns/1ps
module dcas_tx
  import dcas_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire dcas_cfg_t cfg,
  input wire logic load,
  input wire logic [7:0] din,
  output logic txd,
  output logic busy
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} dcas_txst_t;
  dcas_txst_t state_r; // Frame position.
  logic [7:0] sh_r; // Remaining data bits, next one in bit 0.
  logic [2:0] bit_r; // Data bit being sent.
  logic [7:0] cnt_r; // Ticks spent in the current bit.
  logic par_r; // Running parity.
  logic [6:0] ovs;
  logic [7:0] blen;
  logic bit_end;
  assign ovs = dcas_ovs(cfg.mul_sel);
  // Stop framing may be longer than one bit.
  assign blen = (state_r == TX_STOP) ? dcas_stop(ovs, cfg.stop_sel) : {1'b0, ovs};
  assign bit_end = tick && (cnt_r == blen - 8'h01);
  assign busy = (state_r != TX_IDLE);

  // Tick counter inside a bit; held at zero while idle.
  always_ff @(posedge mclk) begin
    if (sys_rst || state_r == TX_IDLE || bit_end) begin
      cnt_r <= 8'h00;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Frame sequencer; the line marks whenever nothing is being sent.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= TX_IDLE;
      txd <= 1'b1;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      par_r <= 1'b0;
    end else begin
      case (state_r)
        TX_IDLE: begin
          txd <= 1'b1;
          if (load) begin
            sh_r <= din;
            par_r <= cfg.par_odd;
            txd <= 1'b0;
            state_r <= TX_START;
          end
        end
        TX_START: begin
          if (bit_end) begin
            txd <= sh_r[0];
            par_r <= par_r ^ sh_r[0];
            bit_r <= 3'h0;
            state_r <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            sh_r <= sh_r >> 1;
            bit_r <= bit_r + 3'h1;
            if (bit_r == dcas_last(cfg.len_sel)) begin
              txd <= cfg.par_en ? par_r : 1'b1;
              state_r <= cfg.par_en ? TX_PAR : TX_STOP;
            end else begin
              txd <= sh_r[1];
              par_r <= par_r ^ sh_r[1];
            end
          end
        end
        TX_PAR: begin
          if (bit_end) begin
            txd <= 1'b1;
            state_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            state_r <= TX_IDLE;
          end
        end
        default: state_r <= TX_IDLE;
      endcase
    end
  end

  tx_idle_mark_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TX_IDLE |-> txd) else $error("Idle line not marking.");
  tx_start_space_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == TX_IDLE && load |=> !txd && state_r == TX_START)
    else $error("No start bit after load.");
endmodule

// ---- src/dcas_rx.sv ----
// Receive deserialiser of one channel.
`timescale 1ns/1ps
module dcas_rx
  import dcas_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire dcas_cfg_t cfg,
  input wire logic rxd,
  output logic done,
  output dcas_rxres_t res,
  output logic busy
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} dcas_rxst_t;
  dcas_rxst_t state_r; // Frame position.
  logic prev_r; // Line level one cycle ago, for edge detection.
  logic [7:0] sh_r; // Bits arrive at the top and move down.
  logic [2:0] bit_r; // Data bit being received.
  logic [7:0] cnt_r; // Ticks since the last sample point.
  logic par_r; // Running parity check.
  logic [6:0] ovs;
  logic [7:0] lim;
  logic smp;
  assign ovs = dcas_ovs(cfg.mul_sel);
  // Half a bit to the start check, then whole bits, so samples fall at centres.
  assign lim = (state_r == RX_START) ? {2'h0, ovs[6:1]} : {1'b0, ovs};
  assign smp = tick && (cnt_r == lim - 8'h01);
  assign busy = (state_r != RX_IDLE);

  // Edge history of the line.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= rxd;
    end
  end

  // Tick counter between sample points.
  always_ff @(posedge mclk) begin
    if (sys_rst || state_r == RX_IDLE || smp) begin
      cnt_r <= 8'h00;
    end else if (tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // Frame sequencer.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= RX_IDLE;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      par_r <= 1'b0;
      done <= 1'b0;
      res <= '0;
    end else begin
      done <= 1'b0;
      case (state_r)
        RX_IDLE: begin
          if (prev_r && !rxd) begin
            state_r <= RX_START;
          end
        end
        RX_START: begin
          if (smp) begin
            // A short glitch is not a character.
            state_r <= rxd ? RX_IDLE : RX_DATA;
            bit_r <= 3'h0;
            par_r <= cfg.par_odd;
          end
        end
        RX_DATA: begin
          if (smp) begin
            sh_r <= {rxd, sh_r[7:1]};
            par_r <= par_r ^ rxd;
            bit_r <= bit_r + 3'h1;
            if (bit_r == dcas_last(cfg.len_sel)) begin
              state_r <= cfg.par_en ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (smp) begin
            par_r <= par_r ^ rxd;
            state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (smp) begin
            // Right-align short characters; one stop sample ends the frame.
            res.data <= sh_r >> (3'h7 - dcas_last(cfg.len_sel));
            res.perr <= cfg.par_en && par_r;
            res.ferr <= !rxd;
            done <= 1'b1;
            state_r <= RX_IDLE;
          end
        end
        default: state_r <= RX_IDLE;
      endcase
    end
  end

  rx_noise_drop_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == RX_START && smp && rxd |=> state_r == RX_IDLE && !done)
    else $error("Glitch taken as a start bit.");
  rx_frame_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
    state_r == RX_STOP && smp |=> done && res.ferr == !$past(rxd))
    else $error("Framing flag does not follow stop sample.");
  rx_noise_c: cover property (@(posedge mclk) state_r == RX_START && smp && rxd);
endmodule

// ---- src/dcas_top.sv ----
// Dual-channel asynchronous serial controller with an AHB-Lite register slave.
`timescale 1ns/1ps
// Function
// - Idle line marks one; receiver treats it idle.
// - Transmitter sends one zero start bit first.
// - Falling edge on idle line starts reception.
// - Data bits travel least significant first.
// - Parity bit follows last data bit.
// - Stop framing is one; ends the character.
// - Bit timing from local 16x/32x/64x ticks.
// - Two independent full-duplex channels.
// - Bytes become bit stream and back.
// - Generate parity, check it, flag mismatch.
// - Status shows receive, transmit-need, errors.
// - Interrupt on receive, transmit need, error.
// - Separate transmit and receive DMA requests.
// - Wait mode holds ready low until possible.
// - Resample start at half bit; reject noise.
// - Five to eight data bits per character.
// - Stop length one, one and half, two.
// - Parity odd, even or disabled.
module dcas_top
  import dcas_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [DCAS_CH-1:0] rxd,
  output logic [DCAS_CH-1:0] txd,
  output logic [DCAS_CH-1:0] dma_tx_req,
  output logic [DCAS_CH-1:0] dma_rx_req,
  output logic irq
);

  // ******************************************************************
  // Bus data phase state
  // ******************************************************************

  // Pending data phase, captured at an accepted address phase.
  logic dp_v_r;
  // Direction of the pending access.
  logic dp_wr_r;
  // Channel that the pending access addresses.
  logic dp_ch_r;
  // Register offset inside the channel window.
  logic [3:0] dp_off_r;
  // The address lies inside the two channel windows.
  logic dp_hit_r;
  // Data-register access that must wait for the channel.
  logic stall;
  // The data phase completes in this cycle.
  logic dp_done;
  // Per-channel view of the stall condition.
  logic [DCAS_CH-1:0] stall_ch;

  // ******************************************************************
  // Per-channel state, one element driven by each channel slice
  // ******************************************************************

  // Control word of each channel.
  dcas_cfg_t cfg_r [DCAS_CH];
  // Divider reload value: a tick every div_r+1 clocks.
  logic [15:0] div_r [DCAS_CH];
  // Divider count.
  logic [15:0] dcnt_r [DCAS_CH];
  // Oversampling tick, one clock wide.
  logic [DCAS_CH-1:0] tick;
  // Byte waiting for the transmitter.
  logic [7:0] tx_hold_r [DCAS_CH];
  // The holding register is occupied.
  logic [DCAS_CH-1:0] tx_full_r;
  // Transmitter is inside a frame.
  logic [DCAS_CH-1:0] tx_busy;
  // Hand the held byte to the serialiser.
  logic [DCAS_CH-1:0] tx_ld;
  // Last received byte.
  logic [7:0] rx_data_r [DCAS_CH];
  // A received byte is waiting to be read.
  logic [DCAS_CH-1:0] rx_av_r;
  // Sticky error flags.
  logic [DCAS_CH-1:0] perr_r;
  logic [DCAS_CH-1:0] ferr_r;
  logic [DCAS_CH-1:0] ovr_r;
  // Receiver outputs.
  logic [DCAS_CH-1:0] rx_done;
  logic [DCAS_CH-1:0] rx_busy;
  dcas_rxres_t rx_res [DCAS_CH];
  // Per-channel interrupt request.
  logic [DCAS_CH-1:0] irq_ch;
  // Status word of each channel.
  logic [31:0] stat [DCAS_CH];

  // ******************************************************************
  // AHB-Lite slave front end
  // ******************************************************************

  // Take an address phase whenever the bus is ready; hold it otherwise.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dp_v_r <= 1'b0;
      dp_wr_r <= 1'b0;
      dp_ch_r <= 1'b0;
      dp_off_r <= 4'h0;
      dp_hit_r <= 1'b0;
    end else if (hready) begin
      // Only whole-word single transfers are expected, so hsize is not decoded.
      dp_v_r <= hsel && htrans[1];
      dp_wr_r <= hwrite;
      dp_ch_r <= haddr[DCAS_CH_BIT];
      dp_off_r <= haddr[3:0];
      dp_hit_r <= (haddr[31:DCAS_CH_BIT+1] == '0);
    end
  end

  // Wait mode stretches a data access until the channel can take or give a byte.
  assign stall = |stall_ch;
  assign hreadyout = !stall;
  assign hresp = 1'b0;
  assign dp_done = dp_v_r && dp_hit_r && !stall;

  // Read mux; unmapped addresses and reserved bits read as zero.
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dp_v_r && dp_hit_r && !dp_wr_r) begin
      case (dp_off_r)
        DCAS_OFF_DATA: hrdata = {24'h00_0000, rx_data_r[dp_ch_r]};
        DCAS_OFF_STAT: hrdata = stat[dp_ch_r];
        DCAS_OFF_CTRL: hrdata = {19'h0_0000, cfg_r[dp_ch_r]};
        DCAS_OFF_DIV: hrdata = {16'h0000, div_r[dp_ch_r]};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ******************************************************************
  // Channels
  // ******************************************************************

  genvar ch;
  generate
    for (ch = 0; ch < DCAS_CH; ch++) begin : g_ch
      // Accesses of this slice in the completing data phase.
      logic sel;
      logic wr_data;
      logic rd_data;
      logic wr_stat;
      assign sel = dp_done && (dp_ch_r == 1'(ch));
      assign wr_data = sel && dp_wr_r && dp_off_r == DCAS_OFF_DATA;
      assign rd_data = sel && !dp_wr_r && dp_off_r == DCAS_OFF_DATA;
      assign wr_stat = sel && dp_wr_r && dp_off_r == DCAS_OFF_STAT;
      // Stall only while the slot is full on a write or empty on a read.
      assign stall_ch[ch] = dp_v_r && dp_hit_r && dp_ch_r == 1'(ch) &&
        dp_off_r == DCAS_OFF_DATA && cfg_r[ch].wait_en &&
        (dp_wr_r ? tx_full_r[ch] : !rx_av_r[ch]);

      // Control and divider registers.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          cfg_r[ch] <= dcas_cfg_t'(DCAS_CTRL_RST);
          div_r[ch] <= DCAS_DIV_RST;
        end else if (sel && dp_wr_r) begin
          if (dp_off_r == DCAS_OFF_CTRL) begin
            cfg_r[ch] <= dcas_cfg_t'(hwdata[12:0]);
          end
          if (dp_off_r == DCAS_OFF_DIV) begin
            div_r[ch] <= hwdata[15:0];
          end
        end
      end

      // Local bit-clock divider; each channel has its own rate.
      always_ff @(posedge mclk) begin
        if (sys_rst || tick[ch]) begin
          dcnt_r[ch] <= 16'h0000;
        end else begin
          dcnt_r[ch] <= dcnt_r[ch] + 16'h0001;
        end
      end
      assign tick[ch] = (dcnt_r[ch] >= div_r[ch]);

      // Transmit holding register; a new byte wins over the hand-off.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          tx_hold_r[ch] <= 8'h00;
          tx_full_r[ch] <= 1'b0;
        end else begin
          if (wr_data) begin
            tx_hold_r[ch] <= hwdata[7:0];
          end
          tx_full_r[ch] <= wr_data || (tx_full_r[ch] && !tx_ld[ch]);
        end
      end
      assign tx_ld[ch] = tx_full_r[ch] && !tx_busy[ch];

      // Receive holding register; an arriving byte wins over the read clear.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          rx_data_r[ch] <= 8'h00;
          rx_av_r[ch] <= 1'b0;
        end else begin
          if (rx_done[ch]) begin
            rx_data_r[ch] <= rx_res[ch].data;
          end
          rx_av_r[ch] <= rx_done[ch] || (rx_av_r[ch] && !rd_data);
        end
      end

      // Sticky errors, cleared by writing one; a new event wins over the clear.
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          perr_r[ch] <= 1'b0;
          ferr_r[ch] <= 1'b0;
          ovr_r[ch] <= 1'b0;
        end else begin
          perr_r[ch] <= (rx_done[ch] && rx_res[ch].perr) ||
            (perr_r[ch] && !(wr_stat && hwdata[DCAS_ST_PERR]));
          ferr_r[ch] <= (rx_done[ch] && rx_res[ch].ferr) ||
            (ferr_r[ch] && !(wr_stat && hwdata[DCAS_ST_FERR]));
          // Overrun: the previous byte was still unread when a new one landed.
          ovr_r[ch] <= (rx_done[ch] && rx_av_r[ch] && !rd_data) ||
            (ovr_r[ch] && !(wr_stat && hwdata[DCAS_ST_OVR]));
        end
      end

      // Status word: readiness, errors and activity.
      always_comb begin
        stat[ch] = 32'h0000_0000;
        stat[ch][DCAS_ST_RXAV] = rx_av_r[ch];
        stat[ch][DCAS_ST_TXND] = !tx_full_r[ch];
        stat[ch][DCAS_ST_PERR] = perr_r[ch];
        stat[ch][DCAS_ST_FERR] = ferr_r[ch];
        stat[ch][DCAS_ST_OVR] = ovr_r[ch];
        stat[ch][DCAS_ST_TXBSY] = tx_busy[ch];
        stat[ch][DCAS_ST_RXBSY] = rx_busy[ch];
      end

      // DMA requests are levels; the controller answers with DATA accesses.
      assign dma_tx_req[ch] = cfg_r[ch].dma_en && !tx_full_r[ch];
      assign dma_rx_req[ch] = cfg_r[ch].dma_en && rx_av_r[ch];
      assign irq_ch[ch] = (cfg_r[ch].rx_ie && rx_av_r[ch]) ||
        (cfg_r[ch].tx_ie && !tx_full_r[ch]) ||
        (cfg_r[ch].err_ie && (perr_r[ch] || ferr_r[ch] || ovr_r[ch]));

      dcas_tx u_tx (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick[ch]),
        .cfg(cfg_r[ch]),
        .load(tx_ld[ch]),
        .din(tx_hold_r[ch]),
        .txd(txd[ch]),
        .busy(tx_busy[ch])
      );

      dcas_rx u_rx (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .tick(tick[ch]),
        .cfg(cfg_r[ch]),
        .rxd(rxd[ch]),
        .done(rx_done[ch]),
        .res(rx_res[ch]),
        .busy(rx_busy[ch])
      );

      // **************************************************************
      // Checks of this channel
      // **************************************************************

      wait_stall_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dp_v_r && dp_hit_r && dp_ch_r == 1'(ch) && !dp_wr_r &&
        dp_off_r == DCAS_OFF_DATA && cfg_r[ch].wait_en && !rx_av_r[ch] |-> !hreadyout)
        else $error("Wait-mode read not stalled.");
      dma_req_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cfg_r[ch].dma_en && rx_done[ch] |=> dma_rx_req[ch])
        else $error("Receive DMA request missing.");
      rx_set_wins_a: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_done[ch] && rd_data |=> rx_av_r[ch])
        else $error("Arriving byte lost to read clear.");
      // A byte written in the hand-off cycle refills the slot, so only a quiet hand-off is checked.
      tx_handoff_a: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_ld[ch] && !wr_data |=> tx_busy[ch] && !tx_full_r[ch])
        else $error("Held byte not handed to transmitter.");
      // The sticky flag lands one cycle after the result and the request one cycle later.
      irq_err_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cfg_r[ch].err_ie && rx_done[ch] && rx_res[ch].perr |-> ##2 irq)
        else $error("Parity error raised no interrupt.");
      perr_c: cover property (@(posedge mclk) rx_done[ch] && rx_res[ch].perr);
      stall_c: cover property (@(posedge mclk) stall_ch[ch] ##1 !stall_ch[ch]);
      frame_c: cover property (@(posedge mclk) rx_done[ch] && !rx_res[ch].ferr);
    end
  endgenerate

  // One request line gathers both channels.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |irq_ch;
    end
  end

endmodule

// ---- verification/dcas_term.sv ----
// Remote serial station model facing both channels.
`timescale 1ns/1ps
module dcas_term (
  input wire logic mclk,
  input wire logic [1:0] line_in,
  output logic [1:0] line_out
);
  int bt = 16; // Clocks per bit time.
  int nb = 8; // Data bits per character.
  int pe = 0; // Parity enabled.
  int po = 0; // Odd parity.
  logic [9:0] got[$]; // Captured frames, stop bit above the last.
  initial line_out = 2'h3; // Idle lines mark.
  // Frames one character; parity or stop may be spoiled on purpose.
  task automatic send(input int ch, input logic [7:0] d, input int bad_p, input int bad_s);
    logic [11:0] f; // Start, data, parity, stop, then idle.
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[1 + i] = d[i];
    if (pe != 0) f[1 + nb] = ^(d & 8'((1 << nb) - 1)) ^ po[0] ^ bad_p[0];
    f[1 + nb + pe] = ~bad_s[0];
    for (int i = 0; i < nb + pe + 3; i++) begin
      @(posedge mclk);
      line_out[ch] <= f[i];
      repeat (bt - 1) @(posedge mclk);
    end
  endtask
  // A low pulse far shorter than half a bit.
  task automatic glitch(input int ch);
    @(posedge mclk);
    line_out[ch] <= 1'b0;
    repeat (bt / 4) @(posedge mclk);
    line_out[ch] <= 1'b1;
  endtask
  // Samples each bit at its centre, as a real station would.
  for (genvar c = 0; c < 2; c++) begin : cap_g
    initial begin
      logic [9:0] s;
      forever begin
        @(negedge line_in[c]);
        s = '0;
        repeat (bt / 2) @(posedge mclk);
        for (int i = 0; i <= nb + pe; i++) begin
          repeat (bt) @(posedge mclk);
          s[i] = line_in[c];
        end
        got.push_back(s);
      end
    end
  end
endmodule

// ---- verification/test_dual_channel_async_serial_channel.sv ----
// Self-checking bench of the dual-channel serial block.
`timescale 1ns/1ps
module test_dual_channel_async_serial_channel;
  import dcas_pkg::*;
  logic mclk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0] htrans, rxd, txd, dma_tx_req, dma_rx_req;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, v;
  int error_cnt, n_checks;
  assign hready = hreadyout; // The one slave drives the bus ready.
  dcas_top dut_u (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hrdata, .hresp, .rxd, .txd, .dma_tx_req, .dma_rx_req, .irq);
  dcas_term term_u (.mclk, .line_in(txd), .line_out(rxd));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // **********
  // Bus cycles and comparison
  // **********
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d, v);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, v);
    chk(v & m, e);
  endtask
  // Polls a status bit; the limit of 4000 reads cuts a hang short.
  task automatic waitst(input logic [31:0] a, input int b, input logic s);
    v = ~{32{s}};
    for (int i = 0; i < 4000 && v[b] !== s; i++) bus(1'b0, a, 32'h0, v);
  endtask
  // Expected line frame as the station captures it.
  function automatic logic [9:0] frame(input logic [7:0] d, input int nb, pe, po);
    logic [9:0] f;
    f = 10'(d & 8'((1 << nb) - 1));
    if (pe != 0) f[nb] = ^f ^ po[0];
    f[nb + pe] = 1'b1;
    return f;
  endfunction
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end
  // Each pass changes parity and stop, length every second pass and rate in passes 5 to 7, alternating channels.
  initial begin
    int ch, nb, pe, po;
    logic [31:0] d, b;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    sys_rst = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    void'($urandom(37));
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk(32'(txd), 32'h3);
    rdc(32'h8, 32'h1fff, 32'hc);
    rdc(32'h4, 32'h1f, 32'h2);
    rdc(32'h20, '1, 32'h0);
    chk(32'(hresp), 32'h0);
    for (int k = 0; k < 8; k++) begin
      ch = k % 2;
      b = 32'(ch) << 4;
      nb = 5 + k / 2;
      pe = int'(k % 3 != 0);
      po = int'(k % 3 == 2);
      d = $urandom;
      term_u.bt = 16 * (1 + int'(k == 6)) * (1 + int'(k == 7)) * (1 + 3 * int'(k == 5));
      term_u.nb = nb;
      term_u.pe = pe;
      term_u.po = po;
      // Pass 5 runs at x64 and pass 4 also enables the error interrupt.
      wr(b + 8, 32'(int'(k == 7) | int'(k == 5) << 1 | k / 2 << 2 | k % 3 << 4 | pe << 6 |
        po << 7 | 1 << 10 | int'(k == 4) << 12));
      wr(b + 12, 32'(k == 6));
      fork
        term_u.send(ch, d[7:0], int'(k == 4), int'(k == 5));
        wr(b, d);
      join
      waitst(b + 4, 0, 1'b1);
      // The request is registered, so let it settle one edge after the flag.
      @(posedge mclk);
      chk(32'(irq), 32'h1);
      rdc(b + 4, 32'hd, 32'(1 | int'(k == 4) << 2 | int'(k == 5) << 3));
      rdc(b, 32'hff, d & ((32'h1 << nb) - 1));
      wr(b + 4, 32'h1c);
      wait (term_u.got.size() != 0);
      chk(32'(term_u.got.pop_front()), 32'(frame(d[7:0], nb, pe, po)));
      waitst(b + 4, 5, 1'b0);
    end
    term_u.glitch(1);
    repeat (400) @(posedge mclk);
    rdc(32'h14, 32'h41, 32'h0);
    term_u.bt = 16;
    term_u.nb = 8;
    term_u.pe = 0;
    // Channel 0 still holds the halved rate of pass 6; restore one tick per clock.
    wr(32'hc, 32'h0);
    wr(32'h8, 32'h30c);
    @(posedge mclk);
    chk(32'(dma_tx_req), 32'h1);
    d = $urandom;
    term_u.send(0, d[7:0], 0, 0);
    waitst(32'h4, 0, 1'b1);
    chk(32'(dma_rx_req), 32'h1);
    rdc(32'h0, 32'hff, d & 32'hff);
    fork
      term_u.send(0, ~d[7:0], 0, 0);
      rdc(32'h0, 32'hff, ~d & 32'hff);
    join
    give_verdict();
  end
endmodule
